/* design/vps_regs.svh */
`ifndef VPS_REGS_SVH
`define VPS_REGS_SVH
// clocking
`define VPS_REF_HZ 100000000
`define VPS_BCLK_128_HZ 128000
`define VPS_BCLK_256_HZ 256000
`define VPS_BCLK_512_HZ 512000
`define VPS_FRAME_HZ 8000
`define VPS_HALF_128 (`VPS_REF_HZ / (2 * `VPS_BCLK_128_HZ))
`define VPS_HALF_256 (`VPS_REF_HZ / (2 * `VPS_BCLK_256_HZ))
`define VPS_HALF_512 (`VPS_REF_HZ / (2 * `VPS_BCLK_512_HZ))
`define VPS_FBITS_128 (`VPS_BCLK_128_HZ / `VPS_FRAME_HZ)
`define VPS_FBITS_256 (`VPS_BCLK_256_HZ / `VPS_FRAME_HZ)
`define VPS_FBITS_512 (`VPS_BCLK_512_HZ / `VPS_FRAME_HZ)
// framing
`define VPS_SYNC_LONG 8
`define VPS_SYNC_LONG16 16
`define VPS_WIN8 7'd32
`define VPS_WIN16 7'd64
`define VPS_BIT_IDLE 7'd64
`define VPS_LAST8 4'd7
`define VPS_LAST16 4'd15
`define VPS_ISDN_MASK 4'h3
`define VPS_THREE_MASK 4'h7
// pin reset: clkOut clkOeN syncOut syncOeN dataOut dataOeN
`define VPS_PINS_RST 6'b010101
`endif

/* design/vps_pkg.sv */
package vps_pkg;
  typedef enum logic [1:0] {FR_LONG = 2'h0, FR_SHORT = 2'h1, FR_ISDN = 2'h2} vps_frame_e;
  typedef enum logic [1:0] {FMT_LIN13 = 2'h0, FMT_LIN16 = 2'h1, FMT_ULAW = 2'h2,
                            FMT_ALAW = 2'h3} vps_fmt_e;
  typedef enum logic [1:0] {PAD_SIGN = 2'h0, PAD_ZERO = 2'h1, PAD_ATTN = 2'h2} vps_pad_e;
  typedef enum logic [1:0] {RATE_128 = 2'h0, RATE_256 = 2'h1, RATE_512 = 2'h2} vps_rate_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} vps_state_e;
  typedef struct packed {
    logic master;
    vps_frame_e framing;
    vps_fmt_e fmt;
    vps_pad_e pad;
    logic [2:0] attn;
    logic slot16;
    logic littleEnd;
    logic relEarly;
    logic mute;
    logic syncOff;
    logic fastSynth;
    logic longSync16;
    vps_rate_e rate;
    logic [7:0] cntHalf;
    logic [7:0] syncLimit;
    logic [3:0] slotMask;
  } vps_cfg_s;
  typedef struct packed {
    logic clkOut;
    logic clkOeN;
    logic syncOut;
    logic syncOeN;
    logic dataOut;
    logic dataOeN;
  } vps_pins_s;
  typedef logic [3:0][15:0] vps_words_t;
endpackage

/* design/vps_sync.sv */
`timescale 1ns/1ps
module vps_sync (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [2:0] d,
  output logic [2:0] q
);
  logic [2:0] meta_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 3'h0;
      q <= 3'h0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* design/vps_clkgen.sv */
`timescale 1ns/1ps
`include "vps_regs.svh"
module vps_clkgen
  import vps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire vps_cfg_s cfg,
  output logic bclk_q,
  output logic sync_q
);
  // ************************************************************
  // divider and frame counter
  // ************************************************************
  logic [8:0] div_q;
  logic [10:0] bit_q;
  wire [8:0] slowHalf = (cfg.rate == RATE_512) ? 9'(`VPS_HALF_512) :
                        (cfg.rate == RATE_256) ? 9'(`VPS_HALF_256) : 9'(`VPS_HALF_128);
  wire [10:0] slowBits = (cfg.rate == RATE_512) ? 11'(`VPS_FBITS_512) :
                         (cfg.rate == RATE_256) ? 11'(`VPS_FBITS_256) : 11'(`VPS_FBITS_128);
  wire [8:0] half = cfg.fastSynth ? {1'b0, cfg.cntHalf} : slowHalf; // [R20]
  wire [10:0] frameBits = cfg.fastSynth ? {cfg.syncLimit, 3'h0} : slowBits; // [R20]
  // a zero divisor behaves as one rather than stalling the clock
  wire tick = ({1'b0, div_q} + 10'h1) >= {1'b0, half};
  wire [10:0] bitD = ((bit_q + 11'h1) >= frameBits) ? 11'h0 : bit_q + 11'h1;
  wire [10:0] syncLen = (cfg.fastSynth && cfg.longSync16) ? 11'(`VPS_SYNC_LONG16) :
                        11'(`VPS_SYNC_LONG); // [R04] [R21]
  wire syncD = cfg.syncOff ? 1'b0 : // [R19]
               (cfg.framing == FR_SHORT) ? (bitD == frameBits - 11'h1) : // [R09]
               (bitD < syncLen); // [R04]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 9'h0;
      bclk_q <= 1'b0;
      bit_q <= 11'h7ff;
      sync_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        div_q <= 9'h0;
        bclk_q <= 1'b0;
        bit_q <= 11'h7ff;
        sync_q <= 1'b0;
      end else if (tick) begin
        div_q <= 9'h0;
        bclk_q <= !bclk_q;
        if (!bclk_q) begin
          bit_q <= bitD;
          sync_q <= syncD;
        end
      end else begin
        div_q <= div_q + 9'h1;
      end
    end
  end
endmodule

/* design/vps_top.sv */
// Operation
// R01 - at most three voice channels at once
// R02 - master drives clock and sync; slave receives
// R03 - long frame: sync rising edge starts word
// R04 - master long frame: sync high eight bits
// R05 - slave long sync width one bit to half
// R06 - sample input falling, change output rising
// R07 - release output after slot, early or late
// R08 - short frame: sync falling edge starts word
// R09 - short frame sync lasts one bit
// R10 - any of first four slots, three max
// R11 - isdn mode gives both bearer channels
// R12 - isdn: sync rising edge starts 8 kHz frame
// R13 - 8-bit slots only with 8-bit formats (isdn here uses 8-bit slots for every format)
// R14 - 16-bit slots take all formats
// R15 - 13/16 linear, mu-law, a-law at 8 ks/s
// R16 - bit order selectable little or big
// R17 - pad unused bits: sign, zero, attenuation
// R18 - mute drives zero on output
// R19 - master may hold sync low, clock runs
// R20 - slow source gives 128/256/512 kHz, 8 kHz
// R21 - fast source long sync 8 or 16
// R22 - settings load only while idle
`timescale 1ns/1ps
`include "vps_regs.svh"
module vps_top
  import vps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic portEnable,
  input wire vps_cfg_s cfgIn,
  input wire vps_words_t txSample,
  input wire logic bitClkIn,
  input wire logic syncIn,
  input wire logic dataIn,
  output vps_pins_s pins,
  output vps_words_t rxSample,
  output logic [3:0] rxStrobe,
  output logic txTake,
  output logic running
);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] chanLimit(input logic [3:0] m);
    chanLimit = (&m) ? `VPS_THREE_MASK : m; // [R01] [R10]
  endfunction

  function automatic logic [1:0] slotOf(input logic [6:0] b, input logic w);
    slotOf = w ? b[5:4] : b[4:3];
  endfunction

  function automatic logic [3:0] posOf(input logic [6:0] b, input logic w);
    posOf = w ? b[3:0] : {1'b0, b[2:0]};
  endfunction

  // slot word is left justified, except that sign padding right justifies it; an 8-cycle slot uses the top byte
  function automatic logic [15:0] buildWord(input logic [15:0] s, input vps_fmt_e f,
                                            input vps_pad_e p, input logic [2:0] a,
                                            input logic w);
    logic b8;
    logic b13;
    b8 = (f == FMT_ULAW) || (f == FMT_ALAW);
    b13 = (f == FMT_LIN13);
    if (!w || (b8 && p == PAD_ZERO)) begin
      buildWord = {s[7:0], 8'h00};
    end else if (b8) begin
      buildWord = (p == PAD_SIGN) ? {{8{s[7]}}, s[7:0]} : {s[7:0], 5'h00, a}; // [R17]
    end else if (b13) begin
      buildWord = (p == PAD_SIGN) ? {{3{s[12]}}, s[12:0]} : // [R17]
                  (p == PAD_ATTN) ? {s[12:0], a} : {s[12:0], 3'h0}; // [R15]
    end else begin
      buildWord = s; // [R15]
    end
  endfunction

  // inverse of buildWord; linear samples come back sign extended
  function automatic logic [15:0] getSample(input logic [15:0] w, input vps_fmt_e f,
                                            input vps_pad_e p, input logic l);
    if ((f == FMT_ULAW) || (f == FMT_ALAW)) begin
      getSample = {8'h00, (l && p == PAD_SIGN) ? w[7:0] : w[15:8]};
    end else if (f == FMT_LIN13) begin
      getSample = (p == PAD_SIGN) ? {{3{w[12]}}, w[12:0]} : {{3{w[15]}}, w[15:3]};
    end else begin
      getSample = w;
    end
  endfunction

  // ************************************************************
  // state and configuration
  // ************************************************************
  vps_state_e st_q;
  vps_state_e st_d;
  vps_cfg_s cfg_q;

  always_comb begin
    unique case (st_q)
      ST_IDLE: st_d = portEnable ? ST_RUN : ST_IDLE;
      ST_RUN: st_d = portEnable ? ST_RUN : ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cfg_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      if (st_q == ST_IDLE) begin
        cfg_q <= cfgIn; // [R22]
      end
    end
  end

  assign running = st_q[1];
  wire isRun = (st_q == ST_RUN);
  wire is8 = (cfg_q.fmt == FMT_ULAW) || (cfg_q.fmt == FMT_ALAW);
  wire isIsdn = (cfg_q.framing == FR_ISDN);
  wire isShort = (cfg_q.framing == FR_SHORT);
  wire l16 = !isIsdn && (cfg_q.slot16 || !is8); // [R13] [R14]
  wire [3:0] maskEff = chanLimit(isIsdn ? `VPS_ISDN_MASK : cfg_q.slotMask); // [R11]
  wire [6:0] winLen = l16 ? `VPS_WIN16 : `VPS_WIN8;

  // ************************************************************
  // clock and sync sources
  // ************************************************************
  logic [2:0] pinSync;
  logic genClk;
  logic genSync;

  vps_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .d({bitClkIn, syncIn, dataIn}),
    .q(pinSync)
  );

  vps_clkgen u_clkgen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .run(isRun && cfg_q.master),
    .cfg(cfg_q),
    .bclk_q(genClk),
    .sync_q(genSync)
  );

  // the master never listens to its own pins, so pad delay cannot skew framing
  wire bclk = cfg_q.master ? genClk : pinSync[2]; // [R02]
  wire fs = cfg_q.master ? genSync : pinSync[1]; // [R02]
  wire din = pinSync[0];

  // ************************************************************
  // framing
  // ************************************************************
  logic bclk_q;
  logic fsPrev_q;
  logic [6:0] bitPos_q;
  vps_words_t txLatch_q;

  wire rise = ce && isRun && bclk && !bclk_q;
  wire fall = ce && isRun && !bclk && bclk_q;
  // only the sync edge matters, so any slave pulse width is accepted
  wire start = rise && (isShort ? (!fs && fsPrev_q) : // [R08]
                                  (fs && !fsPrev_q)); // [R03] [R05] [R12]
  wire [6:0] bitPos_d = start ? 7'h0 :
                        (bitPos_q == `VPS_BIT_IDLE) ? `VPS_BIT_IDLE : bitPos_q + 7'h1;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bclk_q <= 1'b0;
      fsPrev_q <= 1'b0;
      bitPos_q <= `VPS_BIT_IDLE;
      txLatch_q <= '0;
      txTake <= 1'b0;
    end else if (ce) begin
      bclk_q <= bclk;
      txTake <= start;
      if (!isRun) begin
        bitPos_q <= `VPS_BIT_IDLE;
      end else if (rise) begin
        fsPrev_q <= fs;
        bitPos_q <= bitPos_d;
      end
      if (start) begin
        txLatch_q <= txSample;
      end
    end
  end

  // ************************************************************
  // transmit
  // ************************************************************
  wire [1:0] txSlot = slotOf(bitPos_d, l16);
  wire [3:0] txPos = posOf(bitPos_d, l16);
  wire txAct = (bitPos_d < winLen) && maskEff[txSlot]; // [R10]
  wire [15:0] txRaw = start ? txSample[txSlot] : txLatch_q[txSlot];
  wire [15:0] txWord = buildWord(txRaw, cfg_q.fmt, cfg_q.pad, cfg_q.attn, l16);
  wire [3:0] txIdx = cfg_q.littleEnd ? (l16 ? txPos : txPos + 4'h8) : // [R16]
                     4'hf - txPos;
  wire txBit = cfg_q.mute ? 1'b0 : txWord[txIdx]; // [R18]

  // ************************************************************
  // receive
  // ************************************************************
  logic [15:0] rxShift_q;
  wire [1:0] rxSlot = slotOf(bitPos_q, l16);
  wire [3:0] rxPos = posOf(bitPos_q, l16);
  wire rxAct = (bitPos_q < winLen) && maskEff[rxSlot];
  wire rxLast = (rxPos == (l16 ? `VPS_LAST16 : `VPS_LAST8));
  wire [15:0] rxFull = cfg_q.littleEnd ? {din, rxShift_q[15:1]} : // [R16]
                       {rxShift_q[14:0], din};
  wire [15:0] rxJust = (!cfg_q.littleEnd && !l16) ? {rxFull[7:0], 8'h00} : rxFull;
  wire relNow = fall && rxAct && rxLast && cfg_q.relEarly;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rxShift_q <= 16'h0000;
      rxSample <= '0;
      rxStrobe <= 4'h0;
    end else if (ce) begin
      rxStrobe <= 4'h0;
      if (fall && rxAct) begin
        rxShift_q <= rxFull; // [R06]
        if (rxLast) begin
          rxSample[rxSlot] <= getSample(rxJust, cfg_q.fmt, cfg_q.pad, l16);
          rxStrobe[rxSlot] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pins <= `VPS_PINS_RST;
    end else if (ce) begin
      pins.clkOut <= genClk;
      pins.syncOut <= genSync;
      pins.clkOeN <= !(isRun && cfg_q.master); // [R02]
      pins.syncOeN <= !(isRun && cfg_q.master); // [R02]
      if (!isRun) begin
        pins.dataOut <= 1'b0;
        pins.dataOeN <= 1'b1;
      end else if (rise) begin
        pins.dataOut <= txAct ? txBit : pins.dataOut; // [R06]
        pins.dataOeN <= !txAct; // [R07]
      end else if (relNow) begin
        pins.dataOeN <= 1'b1; // [R07]
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  logic [4:0] hiCnt_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hiCnt_q <= 5'h0;
    end else if (rise) begin
      hiCnt_q <= !fs ? 5'h0 : (&hiCnt_q) ? hiCnt_q : hiCnt_q + 5'h1;
    end
  end
  wire syncEnd = rise && !fs && fsPrev_q && cfg_q.master;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_chan;
    $countones(maskEff) <= 3;
  endproperty
  a_chan: assert property (p_chan) else $error("more than three slots active"); // [R01]
  property p_pins;
    isRun ##1 isRun |-> (pins.clkOeN == !cfg_q.master) && (pins.syncOeN == !cfg_q.master);
  endproperty
  a_pins: assert property (p_pins) else $error("clock or sync drive wrong"); // [R02]
  property p_start;
    rise && !isShort && fs && !fsPrev_q |=> bitPos_q == 7'h0;
  endproperty
  a_start: assert property (p_start) else $error("sync rise did not start word"); // [R03]
  property p_len8;
    syncEnd && !isShort && !cfg_q.fastSynth && !cfg_q.syncOff |-> hiCnt_q == 5'd8;
  endproperty
  a_len8: assert property (p_len8) else $error("long sync not eight bits"); // [R04]
  property p_txedge;
    isRun && $changed(pins.dataOut) |-> $past(rise);
  endproperty
  a_txedge: assert property (p_txedge) else $error("output changed off rising edge"); // [R06]
  property p_rxedge;
    $changed(rxShift_q) |-> $past(fall);
  endproperty
  a_rxedge: assert property (p_rxedge) else $error("input taken off falling edge"); // [R06]
  property p_rel;
    rise && !txAct || relNow |=> pins.dataOeN;
  endproperty
  a_rel: assert property (p_rel) else $error("output not released"); // [R07]
  property p_short;
    syncEnd && isShort |-> hiCnt_q == 5'd1;
  endproperty
  a_short: assert property (p_short) else $error("short sync not one bit"); // [R09]
  property p_slotfmt;
    !l16 |-> is8;
  endproperty
  a_slotfmt: assert property (p_slotfmt) else $error("8-cycle slot with wide sample"); // [R13]
  property p_mute;
    isRun && cfg_q.mute |-> ##1 !pins.dataOut;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not zero"); // [R18]
  property p_syncoff;
    isRun && cfg_q.master && cfg_q.syncOff |=> !pins.syncOut ##1 !pins.syncOut;
  endproperty
  a_syncoff: assert property (p_syncoff) else $error("sync not held low"); // [R19]
  property p_len16;
    syncEnd && !isShort && cfg_q.fastSynth && cfg_q.longSync16 && !cfg_q.syncOff
      |-> hiCnt_q == 5'd16;
  endproperty
  a_len16: assert property (p_len16) else $error("long sync not sixteen bits"); // [R21]
  property p_cfg;
    isRun |=> $stable(cfg_q);
  endproperty
  a_cfg: assert property (p_cfg) else $error("settings changed while running"); // [R22]

  c_long: cover property (start && cfg_q.framing == FR_LONG);
  c_short: cover property (start && isShort);
  c_isdn: cover property (start && isIsdn);
  c_rx: cover property (|rxStrobe);
endmodule

/* testbench/vps_codec_model.sv */
`timescale 1ns/1ps
// ****
// codec on the far side: drives bit clock, sync and data as link master
// ****
module vps_codec_model
  import vps_pkg::*;
(
  input wire logic go,
  input wire logic shortSync,
  input wire logic slot16,
  input wire logic [5:0] syncLen,
  input wire logic [3:0] txMask,
  input wire vps_words_t txWord,
  input wire logic dataOut,
  input wire logic dataOeN,
  output logic bitClk,
  output logic sync,
  output logic dataToDev,
  output vps_words_t rxWord,
  output logic [3:0] rxDrv,
  output logic [7:0] frameCnt,
  output logic busy
);
  int len;
  int s;
  int k;
  initial begin
    bitClk = 1'b0;
    sync = 1'b0;
    dataToDev = 1'b0;
    rxWord = '0;
    rxDrv = '0;
    frameCnt = 8'h00;
    busy = 1'b0;
    forever begin
      wait (go === 1'b1);
      // off the reference grid, so no pin edge meets a sampling edge
      #1.25;
      busy = 1'b1;
      len = slot16 ? 16 : 8;
      sync = !shortSync;
      while (busy) begin
        for (int b = 0; b < 64; b++) begin
          s = b / len;
          k = b % len;
          #62.5 bitClk = 1'b1;
          // released line has no pull: keep it moving so a stale bit never passes
          dataToDev = (s < 4 && txMask[s]) ? txWord[s][len-1-k] : !dataToDev;
          #62.5 bitClk = 1'b0;
          if (s < 4) begin
            rxWord[s] = {rxWord[s][14:0] & {15{k != 0}}, dataOut};
            rxDrv[s] = (k == 0 || rxDrv[s]) && !dataOeN;
          end
          if (shortSync)
            sync = b == 62 && go;
          else
            sync = (b + 1) % 64 < syncLen && (b != 63 || go);
        end
        frameCnt++;
        busy = go;
      end
      sync = 1'b0;
    end
  end
endmodule

/* testbench/vps_top_tb.sv */
`timescale 1ns/1ps
`include "vps_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module vps_top_tb
  import vps_pkg::*;
;
  logic ref_clk, resetn, portEnable, txTake, running;
  logic bitClk, sync, dataToDev, go, shortSync, slot16, busy;
  vps_cfg_s cfgIn, c;
  vps_cfg_s rows [10];
  logic [3:0] drvs [10];
  vps_words_t txSample, rxSample, codecTx, codecRx;
  vps_pins_s pins;
  logic [3:0] rxStrobe, txMask, codecDrv;
  logic [5:0] syncLen;
  logic [7:0] frameCnt;
  int errCount, checks, hi, gap, cr, tk, rs;
  localparam int bitCyc = 2 * `VPS_HALF_512;

  vps_top uut (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .portEnable(portEnable),
    .cfgIn(cfgIn), .txSample(txSample), .bitClkIn(bitClk), .syncIn(sync),
    .dataIn(dataToDev), .pins(pins), .rxSample(rxSample), .rxStrobe(rxStrobe),
    .txTake(txTake), .running(running));
  vps_codec_model codec (.go(go), .shortSync(shortSync), .slot16(slot16),
    .syncLen(syncLen), .txMask(txMask), .txWord(codecTx), .dataOut(pins.dataOut),
    .dataOeN(pins.dataOeN), .bitClk(bitClk), .sync(sync), .dataToDev(dataToDev),
    .rxWord(codecRx), .rxDrv(codecDrv), .frameCnt(frameCnt), .busy(busy));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end

  // ****
  // expected line images, worked out from format, padding and bit order
  // ****
  function automatic logic [15:0] rev(input logic [15:0] w, input int n);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r[i] = w[n-1-i];
    return r;
  endfunction
  function automatic int nBits(input vps_cfg_s x);
    return x.fmt == FMT_LIN16 ? 16 : x.fmt == FMT_LIN13 ? 13 : 8;
  endfunction
  function automatic int slotLen(input vps_cfg_s x);
    return (x.slot16 || nBits(x) != 8) && x.framing != FR_ISDN ? 16 : 8;
  endfunction
  function automatic logic [15:0] txSeq(input vps_cfg_s x, input logic [15:0] s);
    logic [15:0] w;
    int n;
    n = nBits(x);
    if (slotLen(x) == 8 || n == 16) w = n == 16 ? s : {8'h00, s[7:0]};
    else if (x.pad == PAD_SIGN) w = n == 13 ? {{3{s[12]}}, s[12:0]} : {{8{s[7]}}, s[7:0]};
    else if (x.pad == PAD_ZERO) w = n == 13 ? {s[12:0], 3'h0} : {s[7:0], 8'h00};
    else w = n == 13 ? {s[12:0], x.attn} : {s[7:0], 5'h00, x.attn};
    if (x.mute) w = '0;
    return x.littleEnd ? rev(w, slotLen(x)) : w;
  endfunction
  function automatic logic [15:0] rxExp(input vps_cfg_s x, input logic [15:0] q);
    logic [15:0] w;
    int n;
    n = nBits(x);
    w = slotLen(x) == 8 ? {8'h00, q[7:0]} : q;
    w = x.littleEnd ? rev(w, slotLen(x)) : w;
    if (slotLen(x) == 16 && n < 16 && x.pad != PAD_SIGN) w = w >> (16 - n);
    return n == 13 ? {{3{w[12]}}, w[12:0]} : n == 8 ? {8'h00, w[7:0]} : w;
  endfunction
  function automatic vps_cfg_s mk(input vps_frame_e f, input vps_fmt_e m, input vps_pad_e p,
                                  input logic s16, input logic le, input logic mu,
                                  input logic [3:0] mask);
    vps_cfg_s x;
    x = '0;
    x.framing = f;
    x.fmt = m;
    x.pad = p;
    x.attn = 3'h5;
    x.slot16 = s16;
    x.littleEnd = le;
    x.mute = mu;
    x.slotMask = mask;
    return x;
  endfunction

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic start(input vps_cfg_s x);
    @(posedge ref_clk);
    portEnable <= 1'b0;
    cfgIn <= x;
    repeat (3) @(posedge ref_clk);
    portEnable <= 1'b1;
  endtask
  task automatic runRow(input vps_cfg_s x, input logic [3:0] drv, input int idx);
    vps_cfg_s x2;
    logic [7:0] f0;
    int i;
    shortSync <= x.framing == FR_SHORT;
    slot16 <= slotLen(x) == 16;
    syncLen <= idx[0] ? 6'd1 : 6'd32;
    txMask <= drv;
    start(x);
    x2 = x;
    x2.mute = !x.mute;
    x2.slotMask = ~x.slotMask;
    repeat (2) @(posedge ref_clk);
    cfgIn <= x2;
    go <= 1'b1;
    f0 = frameCnt;
    tk = 0;
    rs = 0;
    for (i = 0; i < 9000 && 8'(frameCnt - f0) < 8'd3; i++) step();
    if (i >= 9000) i = 12000;
    go <= 1'b0;
    for (i = i; i < 12000 && busy !== 1'b0; i++) step();
    repeat (8) step();
    if (i >= 12000) begin
      errCount++;
      stopTest();
    end
    for (int s = 0; s < 4; s++) begin
      `CHK("slot driven", drv[s], codecDrv[s])
      if (drv[s]) begin
        `CHK("tx slot", txSeq(x, txSample[s]), codecRx[s])
        `CHK("rx sample", rxExp(x, codecTx[s]), rxSample[s])
      end
    end
    `CHK("slave clock oe", 2'b11, {pins.clkOeN, pins.syncOeN})
    `CHK("frame starts", x.framing == FR_SHORT ? 3 : 4, tk)
    `CHK("rx strobes", (x.framing == FR_SHORT ? 3 : 4) * $countones(drv), rs)
    $display("row %0d done", idx);
  endtask
  // one clock step that also counts the one-cycle pulses
  task automatic step;
    @(posedge ref_clk);
    tk += txTake;
    rs += $countones(rxStrobe);
  endtask
  task automatic watch(input int n);
    logic ps, pc;
    int t1, sr;
    hi = 0;
    gap = 0;
    cr = 0;
    sr = 0;
    t1 = 0;
    ps = 1'b0;
    pc = pins.clkOut;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (pins.syncOut === 1'b1) hi++;
      if (pins.syncOut === 1'b1 && !ps) begin
        sr++;
        if (sr == 1) t1 = i;
        if (sr == 2) gap = i - t1;
      end
      if (pins.clkOut === 1'b1 && !pc) cr++;
      ps = pins.syncOut;
      pc = pins.clkOut;
    end
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    resetn = 1'b0;
    portEnable = 1'b0;
    cfgIn = '0;
    go = 1'b0;
    shortSync = 1'b0;
    slot16 = 1'b1;
    syncLen = 6'd8;
    txMask = 4'h0;
    txSample = {16'h7c21, 16'h0f85, 16'h5ab3, 16'h9ac3};
    codecTx = {16'h3c96, 16'hc5a1, 16'h6e17, 16'hb4d2};
    rows[0] = mk(FR_LONG, FMT_LIN16, PAD_SIGN, 1'b1, 1'b0, 1'b0, 4'h1);
    rows[1] = mk(FR_LONG, FMT_LIN16, PAD_SIGN, 1'b1, 1'b1, 1'b0, 4'h5);
    rows[2] = mk(FR_LONG, FMT_ULAW, PAD_SIGN, 1'b0, 1'b0, 1'b0, 4'h3);
    rows[3] = mk(FR_SHORT, FMT_LIN13, PAD_SIGN, 1'b1, 1'b0, 1'b0, 4'h1);
    rows[4] = mk(FR_SHORT, FMT_ALAW, PAD_ZERO, 1'b1, 1'b1, 1'b0, 4'h2);
    rows[5] = mk(FR_LONG, FMT_ULAW, PAD_ATTN, 1'b1, 1'b0, 1'b0, 4'h1);
    rows[6] = mk(FR_LONG, FMT_LIN13, PAD_ATTN, 1'b1, 1'b1, 1'b0, 4'h8);
    rows[7] = mk(FR_LONG, FMT_LIN16, PAD_SIGN, 1'b1, 1'b0, 1'b1, 4'h1);
    rows[8] = mk(FR_ISDN, FMT_ULAW, PAD_SIGN, 1'b0, 1'b0, 1'b0, 4'h1);
    rows[9] = mk(FR_LONG, FMT_ALAW, PAD_SIGN, 1'b0, 1'b0, 1'b0, 4'hf);
    rows[1].relEarly = 1'b1;
    drvs = '{4'h1, 4'h5, 4'h3, 4'h1, 4'h2, 4'h1, 4'h8, 4'h1, 4'h3, 4'h7};
    repeat (10) @(posedge ref_clk);
    `CHK("reset pins", `VPS_PINS_RST, pins)
    `CHK("reset running", 1'b0, running)
    resetn <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 10; i++) runRow(rows[i], drvs[i], i);
    c = mk(FR_LONG, FMT_LIN16, PAD_SIGN, 1'b1, 1'b0, 1'b0, 4'h1);
    c.master = 1'b1;
    c.rate = RATE_512;
    for (int j = 0; j < 2; j++) begin
      c.syncOff = j[0];
      start(c);
      watch(27315);
      `CHK("master oe", 2'b00, {pins.clkOeN, pins.syncOeN})
      `CHK("sync high", j ? 0 : 3 * `VPS_SYNC_LONG * 2 * `VPS_HALF_512, hi)
      `CHK("frame length", j ? 0 : `VPS_FBITS_512 * 2 * `VPS_HALF_512, gap)
      `CHK("clock runs", 1'b1, (cr - 1) * bitCyc < 27315 && (cr + 1) * bitCyc > 27315)
      $display("master test %0d done", j);
    end
    resetn <= 1'b0;
    @(posedge ref_clk);
    `CHK("mid reset pins", `VPS_PINS_RST, pins)
    `CHK("mid reset running", 1'b0, running)
    `CHK("mid reset pulses", 5'h00, {rxStrobe, txTake})
    resetn <= 1'b1;
    $display("mid reset test done");
    stopTest();
  end
endmodule
